// *** verilog/rtc_counter_calendar.sv ***
// Real-time counter with prescaler, three counting modes, sync and protection.
`timescale 1ns/100ps
`default_nettype none
module rtc_counter_calendar (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic counting_clock_i,
	input wire logic debug_halt_i,
	input wire logic ext_debug_i,
	input wire logic write_protect_i,
	input wire logic wr_en_i,
	input wire rtc_counter_calendar_pkg::wr_sel_e wr_sel_i,
	input wire logic [31:0] wr_data_i,
	output logic wr_ready_o,
	output logic sync_busy_o,
	output logic enabled_o,
	output logic [31:0] count_value_o,
	output logic [3:0] flags_o,
	output logic irq_o,
	output logic [7:0] per_event_o,
	output logic ovf_event_o,
	output logic [1:0] cmp_event_o
);
	import rtc_counter_calendar_pkg::*;

	state_s st_q;
	state_s st_d;
	cal_s cal_next;
	logic cal_wrap;
	logic gclk_rise;
	logic run;
	logic cnt_tick;
	logic protect;
	logic taken;
	logic disabling;
	logic do_swrst;
	logic m0;
	logic m1;
	logic [3:0] div;
	logic [3:0] tap;
	logic [9:0] presc_nx;
	logic [3:0] fset;
	logic [3:0] fclr;

	////////////////////////////////////////////////////////////////////////////////

	// Synchronised writes: their target lives on the counting side of the block.
	function automatic logic needs_sync(input wr_sel_e s);
		case (s)
			SEL_CTRL, SEL_COUNT, SEL_PER, SEL_COMP0, SEL_COMP1, SEL_MASK0, SEL_MASK1:
				needs_sync = 1'b1;
			default:
				needs_sync = 1'b0;
		endcase
	endfunction : needs_sync

	// Mask selection 0 never matches; 1..6 compare more fields from seconds up.
	function automatic logic cal_match(input logic [31:0] c, input logic [31:0] a,
			input logic [2:0] sel);
		cal_s m;
		m = '0;
		if (sel >= 3'h1) m.second = '1;
		if (sel >= 3'h2) m.minute = '1;
		if (sel >= 3'h3) m.hour = '1;
		if (sel >= 3'h4) m.day = '1;
		if (sel >= 3'h5) m.month = '1;
		if (sel >= 3'h6) m.year = '1;
		cal_match = (sel != 3'h0) && (((c ^ a) & m) == '0);
	endfunction : cal_match

	rtc_calendar_step u_step (
		.now_i(st_q.count),
		.hour_format_i(st_q.hour_format),
		.next_o(cal_next),
		.wrap_o(cal_wrap)
	);

	////////////////////////////////////////////////////////////////////////////////

	always_comb
	begin
		st_d = st_q;
		st_d.per_ev = '0;
		st_d.ovf_ev = 1'b0;
		st_d.cmp_ev = '0;
		fset = '0;
		fclr = '0;
		m0 = 1'b0;
		m1 = 1'b0;
		do_swrst = 1'b0;

		// The counting clock is a foreign pin; two flops before its edge is used.
		st_d.gsync = {st_q.gsync[0], counting_clock_i};
		st_d.gprev = st_q.gsync[1];
		gclk_rise = st_q.gsync[1] & ~st_q.gprev;

		run = st_q.enable && (!debug_halt_i || st_q.dbg_run);

		presc_nx = (gclk_rise && run) ? st_q.presc + 10'h001 : st_q.presc;
		st_d.presc = presc_nx;
		div = (st_q.divider > DIV_MAX) ? DIV_MAX : st_q.divider;
		tap = div - 4'h1;
		if (div == 4'h0)
			cnt_tick = gclk_rise && run;
		else
			cnt_tick = gclk_rise && run && presc_nx[tap] && !st_q.presc[tap];

		for (int n = 0; n < 8; n++)
		begin
			st_d.per_ev[n] = gclk_rise && run && st_q.per_oe[n] && (div != 4'h0)
				&& presc_nx[n + 2] && !st_q.presc[n + 2];
		end

		if (cnt_tick)
		begin
			case (st_q.mode)
				MODE_COUNT32:
				begin
					// compare flags one tick after the match
					m0 = st_q.count == st_q.comp0;
					m1 = st_q.count == st_q.comp1;
					if (m0 && st_q.clear_on_match)
					begin
						st_d.count = '0;
						fset[FLAG_OVF] = 1'b1;
					end
					else
					begin
						st_d.count = st_q.count + 32'h00000001;
						fset[FLAG_OVF] = st_q.count == COUNT32_TOP;
					end
				end
				MODE_COUNT16:
				begin
					m0 = st_q.count[15:0] == st_q.comp0[15:0];
					m1 = st_q.count[15:0] == st_q.comp1[15:0];
					if (st_q.count[15:0] == st_q.period_value)
					begin
						st_d.count = '0;
						fset[FLAG_OVF] = 1'b1;
					end
					else
					begin
						st_d.count = {16'h0000, st_q.count[15:0] + 16'h0001};
					end
				end
				MODE_CALENDAR:
				begin
					// masked alarms; one tick is assumed to be one second
					m0 = cal_match(st_q.count, st_q.comp0, st_q.mask0);
					m1 = cal_match(st_q.count, st_q.comp1, st_q.mask1);
					if (m0 && st_q.clear_on_match)
					begin
						st_d.count = '0;
						fset[FLAG_OVF] = 1'b1;
					end
					else
					begin
						st_d.count = cal_next;
						fset[FLAG_OVF] = cal_wrap;
					end
				end
				default:
				begin
				end
			endcase
			fset[FLAG_CMP0] = m0;
			fset[FLAG_CMP1] = m1;
		end
		st_d.ovf_ev = fset[FLAG_OVF] && st_q.ovf_eo;
		st_d.cmp_ev = fset[FLAG_CMP1:FLAG_CMP0] & st_q.cmp_eo;

		// protection lifted in debug halt and for the external debugger
		protect = write_protect_i && !debug_halt_i && !ext_debug_i;
		// a synced write while busy stalls
		wr_ready_o = !(st_q.pend_valid && needs_sync(wr_sel_i));
		taken = wr_en_i && wr_ready_o && !(protect && wr_sel_i != SEL_FLAGCLR
			&& wr_sel_i != SEL_DEBUG_CONTROL_REGISTER);
		disabling = st_q.pend_valid && st_q.pend_sel == SEL_CTRL
			&& !st_q.pend_data[CTRL_EN_BIT];

		if (taken)
		begin
			case (wr_sel_i)
				SEL_CTRL, SEL_COUNT, SEL_PER, SEL_COMP0, SEL_COMP1, SEL_MASK0, SEL_MASK1:
				begin
					// hand the write to the counting side
					st_d.pend_valid = 1'b1;
					st_d.pend_sel = wr_sel_i;
					st_d.pend_data = wr_data_i;
					st_d.sync_cnt = SYNC_CYCLES;
				end
				SEL_EVENT_CONTROL_REGISTER:
				begin
					if (!st_q.enable)
					begin
						st_d.per_oe = wr_data_i[EV_PER_LSB +: 8];
						st_d.ovf_eo = wr_data_i[EV_OVF_BIT];
						st_d.cmp_eo = wr_data_i[EV_CMP_LSB +: 2];
					end
					else if (disabling)
					begin
						st_d.ev_hold = 1'b1;
						st_d.ev_hold_data = wr_data_i[10:0];
					end
				end
				SEL_INTENSET: st_d.inten = st_q.inten | wr_data_i[3:0];
				SEL_INTENCLR: st_d.inten = st_q.inten & ~wr_data_i[3:0];
				SEL_FLAGCLR: fclr = wr_data_i[3:0];
				SEL_DEBUG_CONTROL_REGISTER: st_d.dbg_run = wr_data_i[0];
				default:
				begin
				end
			endcase
		end

		// busy for a fixed crossing time, then the write lands
		if (st_q.pend_valid)
		begin
			if (st_q.sync_cnt != 2'h1)
			begin
				st_d.sync_cnt = st_q.sync_cnt - 2'h1;
			end
			else
			begin
				st_d.pend_valid = 1'b0;
				fset[FLAG_SYNCRDY] = 1'b1;
				case (st_q.pend_sel)
					SEL_CTRL:
					begin
						do_swrst = st_q.pend_data[SOFT_RESET_BIT_BIT];
						// enable-protected fields only while disabled or disabling
						if (!st_q.enable || !st_q.pend_data[CTRL_EN_BIT])
						begin
							st_d.mode = st_q.pend_data[CTRL_MODE_LSB +: 2];
							st_d.divider = st_q.pend_data[CTRL_DIV_LSB +: 4];
							st_d.clear_on_match = st_q.pend_data[CLEAR_ON_MATCH_BIT_BIT];
							st_d.hour_format = st_q.pend_data[CTRL_HOURFMT_BIT];
						end
						// release a held event control write
						if (st_q.enable && !st_q.pend_data[CTRL_EN_BIT] && st_q.ev_hold)
						begin
							st_d.per_oe = st_q.ev_hold_data[EV_PER_LSB +: 8];
							st_d.ovf_eo = st_q.ev_hold_data[EV_OVF_BIT];
							st_d.cmp_eo = st_q.ev_hold_data[EV_CMP_LSB +: 2];
						end
						st_d.ev_hold = 1'b0;
						st_d.enable = st_q.pend_data[CTRL_EN_BIT];
					end
					SEL_COUNT:
						st_d.count = (st_q.mode == MODE_COUNT16)
							? {16'h0000, st_q.pend_data[15:0]} : st_q.pend_data;
					SEL_PER: st_d.period_value = st_q.pend_data[15:0];
					SEL_COMP0: st_d.comp0 = st_q.pend_data;
					SEL_COMP1: st_d.comp1 = st_q.pend_data;
					SEL_MASK0: st_d.mask0 = st_q.pend_data[2:0];
					SEL_MASK1: st_d.mask1 = st_q.pend_data[2:0];
					default:
					begin
					end
				endcase
			end
		end

		// Hardware set wins over a clear in the same cycle.
		st_d.flags = (st_q.flags & ~fclr) | fset;
		st_d.rd = (st_q.mode == MODE_COUNT16) ? {16'h0000, st_d.count[15:0]} : st_d.count;

		// soft reset keeps debug control and the pin synchroniser
		if (do_swrst)
		begin
			st_d = ST_RST;
			st_d.dbg_run = st_q.dbg_run;
			st_d.gsync = {st_q.gsync[0], counting_clock_i};
			st_d.gprev = st_q.gsync[1];
		end
	end

	// only the power-on reset pin clears the state asynchronously
	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			st_q <= ST_RST;
		else
			st_q <= st_d;
	end

	assign sync_busy_o = st_q.pend_valid;
	assign enabled_o = st_q.enable;
	assign count_value_o = st_q.rd;
	assign flags_o = st_q.flags;
	// one interrupt line for all enabled flags
	assign irq_o = |(st_q.flags & st_q.inten);
	assign per_event_o = st_q.per_ev;
	assign ovf_event_o = st_q.ovf_ev;
	assign cmp_event_o = st_q.cmp_ev;

	////////////////////////////////////////////////////////////////////////////////

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);

	sync_busy_rise_a: assert property (
		taken && needs_sync(wr_sel_i) |=> sync_busy_o)
		else $error("sync busy did not rise after a synchronised write");

	sync_busy_len_a: assert property (
		$rose(sync_busy_o) |-> sync_busy_o [*3] ##1 !sync_busy_o)
		else $error("sync busy did not last exactly three cycles");

	count32_wrap_a: assert property (
		cnt_tick && st_q.mode == MODE_COUNT32 && st_q.count == COUNT32_TOP
		&& !(st_q.clear_on_match && st_q.comp0 == COUNT32_TOP) && !st_q.pend_valid
		|=> st_q.count == '0 && st_q.flags[FLAG_OVF])
		else $error("32-bit counter did not wrap with overflow");

	count16_wrap_a: assert property (
		cnt_tick && st_q.mode == MODE_COUNT16 && st_q.count[15:0] == st_q.period_value
		&& !st_q.pend_valid |=> st_q.count[15:0] == 16'h0000 && st_q.flags[FLAG_OVF])
		else $error("16-bit counter did not wrap at period");

	compare0_flag_a: assert property (
		cnt_tick && st_q.mode == MODE_COUNT32 && st_q.count == st_q.comp0
		&& !st_q.pend_valid |=> st_q.flags[FLAG_CMP0])
		else $error("compare 0 match did not set its flag");

	event_control_register_locked_a: assert property (
		taken && wr_sel_i == SEL_EVENT_CONTROL_REGISTER && st_q.enable && !st_q.pend_valid
		|=> $stable(st_q.per_oe) && $stable(st_q.ovf_eo))
		else $error("event control changed while enabled");

	periodic_off_a: assert property (
		st_q.divider == 4'h0 |=> per_event_o == 8'h00)
		else $error("periodic event with divider zero");

	debug_freeze_a: assert property (
		debug_halt_i && !st_q.dbg_run && !st_q.pend_valid |=> $stable(st_q.presc))
		else $error("prescaler ran during debug halt");

	irq_hold_a: assert property (
		irq_o && !(wr_en_i && (wr_sel_i == SEL_FLAGCLR || wr_sel_i == SEL_INTENCLR))
		&& !st_q.pend_valid |=> irq_o)
		else $error("interrupt dropped without a clear");

	soft_reset_a: assert property (
		st_q.pend_valid && st_q.sync_cnt == 2'h1 && st_q.pend_sel == SEL_CTRL
		&& st_q.pend_data[SOFT_RESET_BIT_BIT] |=> !enabled_o && flags_o == 4'h0
		&& $stable(st_q.dbg_run))
		else $error("soft reset left state behind");

endmodule : rtc_counter_calendar
`default_nettype wire

// *** verilog/rtc_counter_calendar_pkg.sv ***
// Constants, types and reset state shared by the real-time counter/calendar.
//
// Functional notes
// - Only power-on reset or the soft reset bit reinitialise the block.
// - Mode, divider, clear-on-match, hour format: writes only while disabled or with enable written zero; event control only while disabled.
// - Enable-protected writes during a disable are held until the disable completes.
// - Ten-bit prescaler divides counting clock by two to the divider field, capped at ten.
// - Writing enable one starts the block; writing zero stops it.
// - Soft reset restores everything but debug control and the pin synchroniser and leaves block disabled.
// - Mode zero counts 32 bits, wraps to zero and sets overflow flag.
// - Mode zero compares against two 32-bit values; match sets flag next tick.
// - Mode zero clear-on-match with compare 0 clears counter, sets compare and overflow.
// - Mode one counts 16 bits up to period, wraps to zero, sets overflow.
// - Mode one compares against two 16-bit values; match sets flag next tick.
// - Calendar hours kept in 12 or 24 hour form per hour format bit.
// - Calendar holds seconds, minutes, hours, day from 1, month from 1, year.
// - Every year divisible by four is a leap year.
// - After Dec 31 23:59:59 of year 63 wrap to year 0, set overflow.
// - Two masked alarms compared with calendar; match sets alarm flag next tick.
// - Calendar clear-on-match with alarm 0 clears counter, sets alarm and overflow.
// - Periodic event n on rising prescaler bit n+2; none with divider zero.
// - Debug halt stops counting unless debug control keeps it running.
// - Write protection on all but flag clear and debug control writes; lifted in debug.
// - Accesses crossing to the counting clock are synchronised.
// - Sync busy rises at once, falls when done; further synced writes stall.
// - Interrupt line high while any enabled flag is set.
package rtc_counter_calendar_pkg;

	localparam logic [3:0] DIV_MAX = 4'hA;
	localparam logic [1:0] SYNC_CYCLES = 2'h3;

	localparam logic [1:0] MODE_COUNT32 = 2'h0;
	localparam logic [1:0] MODE_COUNT16 = 2'h1;
	localparam logic [1:0] MODE_CALENDAR = 2'h2;

	// Control word bit positions.
	localparam int SOFT_RESET_BIT_BIT = 0;
	localparam int CTRL_EN_BIT = 1;
	localparam int CTRL_MODE_LSB = 2;
	localparam int CTRL_HOURFMT_BIT = 6;
	localparam int CLEAR_ON_MATCH_BIT_BIT = 7;
	localparam int CTRL_DIV_LSB = 8;

	// Event control word bit positions.
	localparam int EV_PER_LSB = 0;
	localparam int EV_OVF_BIT = 8;
	localparam int EV_CMP_LSB = 9;

	// Flag bit positions; the compare flags double as alarm flags in calendar mode.
	localparam int FLAG_OVF = 0;
	localparam int FLAG_CMP0 = 1;
	localparam int FLAG_CMP1 = 2;
	localparam int FLAG_SYNCRDY = 3;

	localparam logic [31:0] COUNT32_TOP = 32'hFFFFFFFF;
	localparam logic [5:0] SEC_MAX = 6'h3B;
	localparam logic [5:0] MIN_MAX = 6'h3B;
	localparam logic [4:0] HOUR24_MAX = 5'h17;
	localparam logic [3:0] HOUR12_TOP = 4'hC;
	localparam logic [3:0] HOUR12_LAST = 4'hB;
	localparam logic [3:0] HOUR12_FIRST = 4'h1;
	localparam logic [4:0] DAY_FIRST = 5'h01;
	localparam logic [3:0] MON_FIRST = 4'h1;
	localparam logic [3:0] MON_MAX = 4'hC;
	localparam logic [3:0] MON_FEB = 4'h2;
	localparam logic [5:0] YEAR_MAX = 6'h3F;
	localparam logic [4:0] DAYS_LONG = 5'h1F;
	localparam logic [4:0] DAYS_SHORT = 5'h1E;
	localparam logic [4:0] DAYS_FEB_LEAP = 5'h1D;
	localparam logic [4:0] DAYS_FEB = 5'h1C;

	typedef enum logic [3:0] {
		SEL_CTRL, SEL_EVENT_CONTROL_REGISTER, SEL_COUNT, SEL_PER, SEL_COMP0, SEL_COMP1, SEL_MASK0,
		SEL_MASK1, SEL_INTENSET, SEL_INTENCLR, SEL_FLAGCLR, SEL_DEBUG_CONTROL_REGISTER
	} wr_sel_e;

	typedef struct packed {
		logic [5:0] year;
		logic [3:0] month;
		logic [4:0] day;
		logic [4:0] hour;
		logic [5:0] minute;
		logic [5:0] second;
	} cal_s;

	typedef struct packed {
		logic [1:0] gsync;
		logic gprev;
		logic [9:0] presc;
		logic enable;
		logic [1:0] mode;
		logic [3:0] divider;
		logic clear_on_match;
		logic hour_format;
		logic [7:0] per_oe;
		logic ovf_eo;
		logic [1:0] cmp_eo;
		logic ev_hold;
		logic [10:0] ev_hold_data;
		logic [31:0] count;
		logic [15:0] period_value;
		logic [31:0] comp0;
		logic [31:0] comp1;
		logic [2:0] mask0;
		logic [2:0] mask1;
		logic [3:0] flags;
		logic [3:0] inten;
		logic dbg_run;
		logic pend_valid;
		logic [1:0] sync_cnt;
		wr_sel_e pend_sel;
		logic [31:0] pend_data;
		logic [7:0] per_ev;
		logic ovf_ev;
		logic [1:0] cmp_ev;
		logic [31:0] rd;
	} state_s;

	localparam state_s ST_RST = '0;

endpackage : rtc_counter_calendar_pkg

// *** verilog/rtc_calendar_step.sv ***
// One-second advance of the packed calendar value.
`timescale 1ns/100ps
`default_nettype none
module rtc_calendar_step (
	input wire rtc_counter_calendar_pkg::cal_s now_i,
	input wire logic hour_format_i,
	output rtc_counter_calendar_pkg::cal_s next_o,
	output logic wrap_o
);
	import rtc_counter_calendar_pkg::*;

	logic day_carry;
	logic [4:0] dim;

	function automatic logic [4:0] days_in(input logic [3:0] month, input logic [5:0] year);
		case (month)
			MON_FEB: days_in = (year[1:0] == 2'h0) ? DAYS_FEB_LEAP : DAYS_FEB;
			4'h4, 4'h6, 4'h9, 4'hB: days_in = DAYS_SHORT;
			default: days_in = DAYS_LONG;
		endcase
	endfunction : days_in

	always_comb
	begin
		next_o = now_i;
		wrap_o = 1'b0;
		day_carry = 1'b0;
		dim = days_in(now_i.month, now_i.year);
		if (now_i.second != SEC_MAX)
		begin
			next_o.second = now_i.second + 6'h01;
		end
		else
		begin
			next_o.second = '0;
			if (now_i.minute != MIN_MAX)
			begin
				next_o.minute = now_i.minute + 6'h01;
			end
			else
			begin
				next_o.minute = '0;
				if (hour_format_i)
				begin
					// Bit 4 is the afternoon marker; midnight reads as 12 before noon.
					if (now_i.hour[3:0] == HOUR12_TOP)
					begin
						next_o.hour = {now_i.hour[4], HOUR12_FIRST};
					end
					else if (now_i.hour[3:0] == HOUR12_LAST)
					begin
						next_o.hour = {~now_i.hour[4], HOUR12_TOP};
						day_carry = now_i.hour[4];
					end
					else
					begin
						next_o.hour = {now_i.hour[4], now_i.hour[3:0] + 4'h1};
					end
				end
				else if (now_i.hour == HOUR24_MAX)
				begin
					next_o.hour = '0;
					day_carry = 1'b1;
				end
				else
				begin
					next_o.hour = now_i.hour + 5'h01;
				end
			end
		end
		if (day_carry)
		begin
			if (now_i.day != dim)
			begin
				next_o.day = now_i.day + 5'h01;
			end
			else
			begin
				next_o.day = DAY_FIRST;
				if (now_i.month != MON_MAX)
				begin
					next_o.month = now_i.month + 4'h1;
				end
				else
				begin
					next_o.month = MON_FIRST;
					// year 63 wraps to year 0
					if (now_i.year == YEAR_MAX)
					begin
						next_o.year = '0;
						wrap_o = 1'b1;
					end
					else
					begin
						next_o.year = now_i.year + 6'h01;
					end
				end
			end
		end
	end

endmodule : rtc_calendar_step
`default_nettype wire

// *** verification/rtc_counter_calendar_tb.sv ***
// Self-checking testbench for the real-time counter and calendar.
`timescale 1ns/100ps
`default_nettype none
module rtc_counter_calendar_tb;
	import rtc_counter_calendar_pkg::*;
	logic ref_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [1:0] gdiv = 2'h0;
	logic counting_clock_i;
	logic debug_halt_i = 1'b0;
	logic ext_debug_i = 1'b0;
	logic write_protect_i = 1'b0;
	logic wr_en_i = 1'b0;
	wr_sel_e wr_sel_i = SEL_CTRL;
	logic [31:0] wr_data_i = 32'h0;
	logic wr_ready_o, sync_busy_o, enabled_o, irq_o, ovf_event_o;
	logic [31:0] count_value_o;
	logic [3:0] flags_o;
	logic [7:0] per_event_o;
	logic [1:0] cmp_event_o;
	int fail_count = 0;
	int tests_run = 0;

	rtc_counter_calendar dut (
		.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .counting_clock_i(counting_clock_i),
		.debug_halt_i(debug_halt_i), .ext_debug_i(ext_debug_i),
		.write_protect_i(write_protect_i), .wr_en_i(wr_en_i), .wr_sel_i(wr_sel_i),
		.wr_data_i(wr_data_i), .wr_ready_o(wr_ready_o), .sync_busy_o(sync_busy_o),
		.enabled_o(enabled_o), .count_value_o(count_value_o), .flags_o(flags_o),
		.irq_o(irq_o), .per_event_o(per_event_o), .ovf_event_o(ovf_event_o),
		.cmp_event_o(cmp_event_o)
	);

	initial
	begin
		forever #50 ref_clk_i = ~ref_clk_i;
	end

	// The generic clock runs free at a quarter of the bus clock so the synchroniser sees each level.
	always_ff @(posedge ref_clk_i) gdiv <= gdiv + 2'h1;
	assign counting_clock_i = gdiv[1];

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			$display("FAIL %s expected %h seen %h", name, exp, seen);
			fail_count++;
		end
	endtask : check

	task automatic conclude();
		$display("Checks run %0d, mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
		begin
			$display("Finished cleanly");
		end
		else
		begin
			$display("Finished with errors");
		end
		$finish;
	endtask : conclude

	// A stalled request is held unchanged until ready is seen at the taking edge.
	task automatic wr_go(input wr_sel_e sel, input logic [31:0] data);
		int n;
		n = 0;
		@(posedge ref_clk_i);
		wr_en_i <= 1'b1;
		wr_sel_i <= sel;
		wr_data_i <= data;
		@(negedge ref_clk_i);
		while (wr_ready_o !== 1'b1 && n < 20)
		begin
			@(negedge ref_clk_i);
			n++;
		end
		@(posedge ref_clk_i);
		wr_en_i <= 1'b0;
	endtask : wr_go

	task automatic wr(input wr_sel_e sel, input logic [31:0] data);
		int n;
		n = 0;
		wr_go(sel, data);
		do
		begin
			@(negedge ref_clk_i);
			n++;
		end
		while (sync_busy_o !== 1'b0 && n < 20);
	endtask : wr

	task automatic go(input logic [31:0] ctrl, input logic [31:0] count);
		wr(SEL_CTRL, ctrl);
		wr(SEL_COUNT, count);
		wr(SEL_FLAGCLR, 32'hF);
		wr(SEL_CTRL, ctrl | 32'h2);
	endtask : go

	task automatic wait_flag(input int b);
		int n;
		n = 0;
		do
		begin
			@(negedge ref_clk_i);
			n++;
		end
		while (flags_o[b] !== 1'b1 && n < 400);
		if (n >= 400)
		begin
			$display("FAIL flag %0d expected 1 seen %b", b, flags_o[b]);
			fail_count++;
		end
	endtask : wait_flag

	// Returns the number of cycles waited, capped at 200 when nothing happens.
	task automatic wait_pulse(output int n);
		n = 0;
		do
		begin
			@(negedge ref_clk_i);
			n++;
		end
		while (per_event_o[0] !== 1'b1 && n < 200);
	endtask : wait_pulse

	task automatic wait_change(output int n);
		logic [31:0] v;
		v = count_value_o;
		n = 0;
		do
		begin
			@(negedge ref_clk_i);
			n++;
		end
		while (count_value_o === v && n < 200);
	endtask : wait_change

	function automatic logic [31:0] cal(input logic [5:0] y, input logic [3:0] mo,
		input logic [4:0] d, input logic [4:0] h, input logic [5:0] mi, input logic [5:0] s);
		return {y, mo, d, h, mi, s};
	endfunction : cal

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_enable();
		check("ready after reset", wr_ready_o, 32'h1);
		check("count after reset", count_value_o, 32'h0);
		@(posedge ref_clk_i);
		wr_en_i <= 1'b1;
		wr_data_i <= 32'h2;
		@(posedge ref_clk_i);
		wr_en_i <= 1'b0;
		wr_sel_i <= SEL_COUNT;
		for (int i = 0; i < 3; i++)
		begin
			@(negedge ref_clk_i);
			check("sync busy", sync_busy_o, 32'h1);
			check("stall while busy", wr_ready_o, 32'h0);
		end
		@(negedge ref_clk_i);
		check("sync busy end", sync_busy_o, 32'h0);
		check("enabled", enabled_o, 32'h1);
		check("sync ready flag", flags_o[3], 32'h1);
	endtask : t_enable

	task automatic t_counters();
		int n;
		wr(SEL_COMP1, 32'hFFFFFFFE);
		go(32'h0, 32'hFFFFFFFC);
		wait_flag(2);
		check("compare 32", count_value_o, 32'hFFFFFFFF);
		wait_flag(0);
		check("wrap 32", count_value_o, 32'h0);
		wr(SEL_COMP0, 32'h6);
		go(32'h80, 32'h3);
		wait_flag(1);
		check("clear match ovf", flags_o[0], 32'h1);
		check("clear match count", count_value_o, 32'h0);
		wr(SEL_COMP1, 32'h00010002);
		wr(SEL_CTRL, 32'h4);
		wr(SEL_COUNT, 32'hABCD0000);
		check("count 16 read", count_value_o, 32'h0);
		wr(SEL_PER, 32'h3);
		go(32'h4, 32'h0);
		wait_flag(2);
		check("compare 16", count_value_o, 32'h3);
		wait_flag(0);
		check("wrap 16", count_value_o, 32'h0);
		go(32'h100, 32'h0);
		wait_change(n);
		wait_change(n);
		check("tick spacing", n, 32'h8);
	endtask : t_counters

	task automatic t_period();
		int n;
		wr(SEL_EVENT_CONTROL_REGISTER, 32'h1);
		wait_pulse(n);
		check("event write discarded", n, 32'hC8);
		wr_go(SEL_CTRL, 32'h100);
		wr(SEL_EVENT_CONTROL_REGISTER, 32'h1);
		wr(SEL_CTRL, 32'h102);
		wait_pulse(n);
		wait_pulse(n);
		check("periodic interval", n, 32'h20);
		wr(SEL_CTRL, 32'h0);
		wr(SEL_CTRL, 32'h2);
		wait_pulse(n);
		check("no events div zero", n, 32'hC8);
	endtask : t_period

	task automatic t_calendar();
		logic [31:0] st [4];
		logic [31:0] ex [4];
		int n;
		st[0] = cal(6'h3F, 4'hC, 5'h1F, 5'h17, 6'h3B, 6'h3B);
		ex[0] = cal(6'h0, 4'h1, 5'h1, 5'h0, 6'h0, 6'h0);
		st[1] = cal(6'h4, 4'h2, 5'h1C, 5'h17, 6'h3B, 6'h3B);
		ex[1] = cal(6'h4, 4'h2, 5'h1D, 5'h0, 6'h0, 6'h0);
		st[2] = cal(6'h5, 4'h2, 5'h1C, 5'h17, 6'h3B, 6'h3B);
		ex[2] = cal(6'h5, 4'h3, 5'h1, 5'h0, 6'h0, 6'h0);
		st[3] = cal(6'h1, 4'h1, 5'h1, 5'h0B, 6'h3B, 6'h3B);
		ex[3] = cal(6'h1, 4'h1, 5'h1, 5'h1C, 6'h0, 6'h0);
		for (int i = 0; i < 4; i++)
		begin
			// every count tick stands for one second here
			go((i == 3) ? 32'h48 : 32'h08, st[i]);
			wait_change(n);
			check("calendar step", count_value_o, ex[i]);
			check("calendar ovf", flags_o[0], (i == 0) ? 32'h1 : 32'h0);
		end
		wr(SEL_COMP0, cal(6'h0, 4'h1, 5'h1, 5'h0, 6'h0, 6'h5));
		wr(SEL_MASK0, 32'h1);
		wr(SEL_CTRL, 32'h88);
		wr(SEL_EVENT_CONTROL_REGISTER, 32'h300);
		go(32'h88, cal(6'h0, 4'h1, 5'h1, 5'h0, 6'h0, 6'h3));
		wait_flag(1);
		check("overflow event", ovf_event_o, 32'h1);
		check("alarm event", cmp_event_o, 32'h1);
		check("alarm ovf", flags_o[0], 32'h1);
		check("alarm clear", count_value_o, 32'h0);
	endtask : t_calendar

	task automatic t_debug();
		logic [31:0] v;
		go(32'h0, 32'h0);
		@(posedge ref_clk_i);
		debug_halt_i <= 1'b1;
		@(negedge ref_clk_i);
		v = count_value_o;
		repeat (40) @(negedge ref_clk_i);
		check("halted count", count_value_o, v);
		wr(SEL_DEBUG_CONTROL_REGISTER, 32'h1);
		repeat (40) @(negedge ref_clk_i);
		check("debug run", count_value_o !== v, 32'h1);
		wr(SEL_CTRL, 32'h1);
		check("soft reset enable", enabled_o, 32'h0);
		check("soft reset count", count_value_o, 32'h0);
		wr(SEL_CTRL, 32'h2);
		repeat (40) @(negedge ref_clk_i);
		check("debug kept", count_value_o !== 32'h0, 32'h1);
		@(posedge ref_clk_i);
		debug_halt_i <= 1'b0;
		write_protect_i <= 1'b1;
		wr(SEL_FLAGCLR, 32'hF);
		check("flag clear exempt", flags_o[3], 32'h0);
		wr(SEL_INTENSET, 32'h8);
		wr(SEL_COUNT, 32'h80000000);
		check("protected count", count_value_o[31], 32'h0);
		@(posedge ref_clk_i);
		ext_debug_i <= 1'b1;
		wr(SEL_COUNT, 32'h0);
		@(posedge ref_clk_i);
		ext_debug_i <= 1'b0;
		check("debugger write", flags_o[3], 32'h1);
		check("irq masked", irq_o, 32'h0);
		@(posedge ref_clk_i);
		debug_halt_i <= 1'b1;
		wr(SEL_INTENSET, 32'h8);
		check("irq raised", irq_o, 32'h1);
		wr(SEL_FLAGCLR, 32'h8);
		check("irq cleared", irq_o, 32'h0);
	endtask : t_debug

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (3) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		@(negedge ref_clk_i);
		t_enable();
		t_counters();
		t_period();
		t_calendar();
		t_debug();
		conclude();
	end

	// The whole sequence needs about a thousand cycles; this limit leaves a wide margin.
	initial
	begin
		repeat (30000) @(posedge ref_clk_i);
		$display("FAIL watchdog expected done seen running");
		fail_count++;
		conclude();
	end
endmodule : rtc_counter_calendar_tb
`default_nettype wire
